// >>> common/dctm_pkg.sv
// Constants, types and tables for the temperature monitor control block
package dctm_pkg;
   localparam int          CLK_MHZ       = 100;
   localparam int          CONV_TIME_MS  = 60;
   localparam int          CONV_CYC_DFLT = CONV_TIME_MS * 1000 * CLK_MHZ;
   localparam int          RATE_UNIT_US  = 62500;
   localparam int          RATE_CYC_DFLT = RATE_UNIT_US * CLK_MHZ;
   localparam logic [7:0]  SENSE_CYC     = 8'h10;
   localparam logic [3:0]  AVG_N         = 4'ha;
   localparam logic [2:0]  RATE_EXP_MAX  = 3'h7;
   localparam int          CFG_MASK_BIT  = 7;
   localparam int          CFG_SLEEP_BIT = 6;
   localparam logic [7:0]  CFG_RST       = 8'h00;
   localparam logic [7:0]  RATE_RST      = 8'h02;
   localparam logic [7:0]  TEMP_RST      = 8'h00;
   localparam logic [7:0]  LIM_HI_RST    = 8'h7f;
   localparam logic [7:0]  LIM_LO_RST    = 8'hc9;
   localparam logic [6:0]  ADDR_RST      = 7'h18;
   localparam logic [2:0]  SEL_CFG       = 3'h0;
   localparam logic [2:0]  SEL_RATE      = 3'h1;
   localparam logic [2:0]  SEL_LIM_BASE  = 3'h2;
   localparam int          LIM_LOC_HI    = 0;
   localparam int          LIM_LOC_LO    = 1;
   localparam int          LIM_REM_HI    = 2;
   localparam int          LIM_REM_LO    = 3;
   localparam int          FLG_LOC_HI    = 0;
   localparam int          FLG_LOC_LO    = 1;
   localparam int          FLG_REM_HI    = 2;
   localparam int          FLG_REM_LO    = 3;
   localparam logic [1:0]  LVL_LOW       = 2'h0;
   localparam logic [1:0]  LVL_OPEN      = 2'h1;
   localparam logic [1:0]  LVL_HIGH      = 2'h2;
   localparam logic [6:0]  ADDR_TAB [9]  = '{7'h18, 7'h19, 7'h1a,
                                            7'h29, 7'h2a, 7'h2b,
                                            7'h4c, 7'h4d, 7'h4e};
   typedef enum logic [2:0] {
      ST_IDLE, ST_SENSE_LO, ST_SENSE_HI, ST_REMOTE, ST_LOCAL, ST_STORE, ST_CMP
   } dctm_state_t;
endpackage : dctm_pkg

// >>> logic/dctm_addr_dec.sv
// Three-level address pin decode into the slave address
`timescale 1ns/100ps
module dctm_addr_dec (
   input  wire logic       rd_lo0,
   input  wire logic       rd_hi0,
   input  wire logic       rd_lo1,
   input  wire logic       rd_hi1,
   output logic [6:0]      addr
);
   import dctm_pkg::*;
   logic [1:0] lvl0;
   logic [1:0] lvl1;
   logic [3:0] idx;
   assign lvl0 = !rd_hi0 ? LVL_LOW : (rd_lo0 ? LVL_HIGH : LVL_OPEN);
   assign lvl1 = !rd_hi1 ? LVL_LOW : (rd_lo1 ? LVL_HIGH : LVL_OPEN);
   assign idx  = 4'({lvl0, 1'b0}) + 4'(lvl0) + 4'(lvl1);
   assign addr = ADDR_TAB[idx];
endmodule : dctm_addr_dec

// >>> logic/dctm_ctrl.sv
// Conversion sequencer, result store, limit flags and alert driver
// Operation
// - Auto conversions only when awake, not sleeping
// - One-shot forces single update of both
// - Two channel phases span about sixty milliseconds
// - Results stored as 8-bit two's complement
// - Compare stored results with limits, set flags
// - Out-of-limit pulls open-drain alert low
// - Both channels updated together on success
// - Sample address pins at conversion start
// - Each address pin decodes three levels
// - Two pins select one of nine addresses
// - Standby input high runs, low sleeps
// - Standby by software bit or pin
// - Conversion period follows rate register
// - Each result averages ten measurements
// - Pin standby blocks one-shot; software permits
// - Pin standby aborts conversion, keeps results
// - Config bit7 masks alert, bit6 sleeps
// - Registers retained during standby
`timescale 1ns/100ps
module dctm_ctrl #(
   parameter int CONV_CYCLES = dctm_pkg::CONV_CYC_DFLT,
   parameter int RATE_CYCLES = dctm_pkg::RATE_CYC_DFLT
) (
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire logic              hw_sleep_n_input,
   input  wire logic              addr_select0_pin_i,
   output logic                   addr_select0_pin_o,
   output logic                   addr_select0_pin_oe,
   input  wire logic              addr_select1_pin_i,
   output logic                   addr_select1_pin_o,
   output logic                   addr_select1_pin_oe,
   input  wire logic              reg_wr,
   input  wire logic [2:0]        reg_sel,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              oneshot_req,
   input  wire logic              status_clr,
   input  wire logic              meas_valid,
   input  wire logic signed [7:0] meas_data,
   output logic                   meas_en_q,
   output logic                   sense_remote_q,
   output logic [7:0]             temp_local_q,
   output logic [7:0]             temp_remote_q,
   output logic [3:0]             status_q,
   output logic [7:0]             cfg_q,
   output logic [7:0]             rate_q,
   output logic [6:0]             slave_addr_q,
   output logic                   alert_pin_o,
   output logic                   alert_pin_oe
);
   import dctm_pkg::*;
   localparam logic [31:0] HALF_CYC = 32'(CONV_CYCLES / 2);
   localparam logic [31:0] UNIT_CYC = 32'(RATE_CYCLES);

   dctm_state_t st_q, st_d;
   logic [1:0]  pin_s1_q, pin_s2_q, rd_lo_q;
   logic        slp_s1_q, slp_s2_q, pend_q, pin_oe_q, pin_o_q, alert_oe_q;
   logic [7:0]  sense_cnt_q, loc_avg_q, rem_avg_q;
   logic [7:0]  lim_q [4];
   logic [31:0] wait_cnt_q, tmr_q, period;
   logic [3:0]  samp_cnt_q;
   logic signed [11:0] sum_q, avg_full;
   logic [6:0]  dec_addr;
   logic [2:0]  rexp;
   logic        hw_on, free_run, start, sense_done, chan_done, converting;
   logic        take, in_chan, leave_chan, tmr_done;
   logic [3:0]  hits;

   dctm_addr_dec u_dec (
      .rd_lo0 (rd_lo_q[0]),
      .rd_hi0 (pin_s2_q[0]),
      .rd_lo1 (rd_lo_q[1]),
      .rd_hi1 (pin_s2_q[1]),
      .addr   (dec_addr)
   );

   assign hw_on      = slp_s2_q;
   // Software bit or pin stops runs
   assign free_run   = hw_on && !cfg_q[CFG_SLEEP_BIT];
   assign rexp       = (rate_q > 8'(RATE_EXP_MAX)) ? RATE_EXP_MAX : rate_q[2:0];
   assign period     = UNIT_CYC << (RATE_EXP_MAX - rexp);
   // Pin standby gates every start, pending or not
   assign start      = st_q == ST_IDLE && hw_on &&
                       (pend_q || (free_run && wait_cnt_q >= period - 32'h1));
   assign sense_done = sense_cnt_q == SENSE_CYC - 8'h1;
   assign in_chan    = st_q == ST_REMOTE || st_q == ST_LOCAL;
   assign tmr_done   = tmr_q >= HALF_CYC - 32'h1;
   assign chan_done  = in_chan && tmr_done && samp_cnt_q == AVG_N;
   assign take       = in_chan && meas_valid && samp_cnt_q != AVG_N;
   assign leave_chan = st_d != st_q;
   assign converting = st_q inside {ST_SENSE_LO, ST_SENSE_HI,
                                    ST_REMOTE, ST_LOCAL};
   assign avg_full   = sum_q / 12'sd10;
   assign hits[FLG_LOC_HI] = $signed(temp_local_q) > $signed(lim_q[LIM_LOC_HI]);
   assign hits[FLG_LOC_LO] = $signed(temp_local_q) < $signed(lim_q[LIM_LOC_LO]);
   assign hits[FLG_REM_HI] = $signed(temp_remote_q) > $signed(lim_q[LIM_REM_HI]);
   assign hits[FLG_REM_LO] = $signed(temp_remote_q) < $signed(lim_q[LIM_REM_LO]);
   assign addr_select0_pin_o  = pin_o_q;
   assign addr_select1_pin_o  = pin_o_q;
   assign addr_select0_pin_oe = pin_oe_q;
   assign addr_select1_pin_oe = pin_oe_q;
   assign alert_pin_oe        = alert_oe_q;

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE:     if (start) st_d = ST_SENSE_LO;
         ST_SENSE_LO: if (sense_done) st_d = ST_SENSE_HI;
         ST_SENSE_HI: if (sense_done) st_d = ST_REMOTE;
         ST_REMOTE:   if (chan_done) st_d = ST_LOCAL;
         ST_LOCAL:    if (chan_done) st_d = ST_STORE;
         ST_STORE:    st_d = ST_CMP;
         ST_CMP:      st_d = ST_IDLE;
      endcase
      if (converting && !hw_on) begin
         st_d = ST_IDLE;
      end
   end

   // Two flops on every pin before use
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
         slp_s1_q <= 1'b0;
         slp_s2_q <= 1'b0;
      end else if (clk_en) begin
         pin_s1_q <= {addr_select1_pin_i, addr_select0_pin_i};
         pin_s2_q <= pin_s1_q;
         slp_s1_q <= hw_sleep_n_input;
         slp_s2_q <= slp_s1_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q       <= ST_IDLE;
         pend_q     <= 1'b0;
         wait_cnt_q <= 32'h0;
      end else if (clk_en) begin
         st_q       <= st_d;
         // One-shot kept only while pin awake; set wins
         pend_q     <= hw_on && (oneshot_req || (pend_q && !start));
         wait_cnt_q <= (start || !free_run) ? 32'h0 : wait_cnt_q + 32'h1;
      end
   end

   // Sensing drives the pin low, then high; floating follows both
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sense_cnt_q  <= 8'h0;
         rd_lo_q      <= 2'h0;
         pin_oe_q     <= 1'b0;
         pin_o_q      <= 1'b0;
         slave_addr_q <= ADDR_RST;
      end else if (clk_en) begin
         sense_cnt_q <= (leave_chan || st_q == ST_IDLE) ? 8'h0
                                                        : sense_cnt_q + 8'h1;
         pin_oe_q    <= st_d == ST_SENSE_LO || st_d == ST_SENSE_HI;
         pin_o_q     <= st_d == ST_SENSE_HI;
         if (st_q == ST_SENSE_LO && sense_done) begin
            rd_lo_q <= pin_s2_q;
         end
         if (st_q == ST_SENSE_HI && st_d == ST_REMOTE) begin
            slave_addr_q <= dec_addr;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tmr_q          <= 32'h0;
         samp_cnt_q     <= 4'h0;
         sum_q          <= 12'sh0;
         rem_avg_q      <= TEMP_RST;
         loc_avg_q      <= TEMP_RST;
         meas_en_q      <= 1'b0;
         sense_remote_q <= 1'b0;
      end else if (clk_en) begin
         tmr_q      <= (in_chan && !leave_chan) ? tmr_q + 32'h1 : 32'h0;
         samp_cnt_q <= (in_chan && !leave_chan) ?
                       samp_cnt_q + 4'(take) : 4'h0;
         sum_q      <= (in_chan && !leave_chan) ?
                       sum_q + (take ? 12'(meas_data) : 12'sh0) : 12'sh0;
         if (st_q == ST_REMOTE && st_d == ST_LOCAL) begin
            rem_avg_q <= avg_full[7:0];
         end
         if (st_q == ST_LOCAL && st_d == ST_STORE) begin
            loc_avg_q <= avg_full[7:0];
         end
         sense_remote_q <= st_d == ST_REMOTE;
         meas_en_q      <= (st_d == ST_REMOTE || st_d == ST_LOCAL) &&
                           !(samp_cnt_q == AVG_N && !leave_chan);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cfg_q <= CFG_RST;
         rate_q <= RATE_RST;
         lim_q <= '{LIM_HI_RST, LIM_LO_RST, LIM_HI_RST, LIM_LO_RST};
      end else if (clk_en && reg_wr) begin
         // Mask and sleep bits live here
         if (reg_sel == SEL_CFG) cfg_q <= reg_wdata;
         if (reg_sel == SEL_RATE) rate_q <= reg_wdata;
         if (reg_sel >= SEL_LIM_BASE && reg_sel < SEL_LIM_BASE + 3'h4) begin
            lim_q[2'(reg_sel - SEL_LIM_BASE)] <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         temp_local_q  <= TEMP_RST;
         temp_remote_q <= TEMP_RST;
         status_q      <= 4'h0;
         alert_oe_q    <= 1'b0;
         alert_pin_o   <= 1'b0;
      end else if (clk_en) begin
         if (st_q == ST_STORE) begin
            temp_local_q  <= loc_avg_q;
            temp_remote_q <= rem_avg_q;
         end
         // Flags set after compare; set beats clear
         status_q <= (status_clr ? 4'h0 : status_q) |
                     ((st_q == ST_CMP) ? hits : 4'h0);
         // Open drain low on any flag
         alert_oe_q  <= |status_q && !cfg_q[CFG_MASK_BIT];
         alert_pin_o <= 1'b0;
      end
   end

   default clocking cb @(posedge clk_sys iff clk_en); endclocking
   default disable iff (!rst_n);

   sequence s_conv_start;
      st_q == ST_IDLE ##1 st_q != ST_IDLE;
   endsequence
   sequence s_chan_swap;
      st_q == ST_REMOTE ##1 st_q == ST_LOCAL;
   endsequence

   property p_no_auto;
      st_q == ST_IDLE && !free_run && !pend_q && !oneshot_req |=>
         st_q == ST_IDLE;
   endproperty
   a_no_auto: assert property (p_no_auto)
      else $error("conversion started while asleep");
   property p_hw_block;
      st_q == ST_IDLE && !hw_on |=> st_q == ST_IDLE && !pend_q;
   endproperty
   a_hw_block: assert property (p_hw_block)
      else $error("conversion started in pin standby");
   property p_abort;
      converting && !hw_on |=> st_q == ST_IDLE && $stable(temp_local_q)
                               && $stable(temp_remote_q);
   endproperty
   a_abort: assert property (p_abort)
      else $error("pin standby did not abort cleanly");
   property p_sense_first;
      s_conv_start |-> st_q == ST_SENSE_LO && pin_oe_q && !pin_o_q;
   endproperty
   a_sense_first: assert property (p_sense_first)
      else $error("conversion did not sense address first");
   property p_addr_hold;
      !(st_q == ST_SENSE_HI && st_d == ST_REMOTE) |=> $stable(slave_addr_q);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("slave address moved outside a start");
   property p_update_end;
      !$stable(temp_local_q) || !$stable(temp_remote_q) |->
         $past(st_q) == ST_STORE;
   endproperty
   a_update_end: assert property (p_update_end)
      else $error("results changed outside commit");
   property p_flag_set;
      st_q == ST_CMP && hits[FLG_REM_HI] |=> status_q[FLG_REM_HI];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("remote high flag not set");
   property p_alert;
      |status_q && !cfg_q[CFG_MASK_BIT] |=> alert_pin_oe && !alert_pin_o;
   endproperty
   a_alert: assert property (p_alert)
      else $error("alert not driven low");
   property p_ten;
      s_chan_swap |-> $past(samp_cnt_q) == AVG_N && samp_cnt_q == 4'h0;
   endproperty
   a_ten: assert property (p_ten)
      else $error("channel ended without ten samples");
   property p_half;
      s_chan_swap |-> $past(tmr_q) >= HALF_CYC - 32'h1;
   endproperty
   a_half: assert property (p_half)
      else $error("channel phase too short");
endmodule : dctm_ctrl

// >>> tb/dctm_far.sv
// Far-side model: converter samples and address pin wiring
`timescale 1ns/100ps
module dctm_far (
   input  wire logic              clk_sys,
   input  wire logic              meas_en_q,
   input  wire logic              sense_remote_q,
   input  wire logic              a0_o,
   input  wire logic              a0_oe,
   input  wire logic              a1_o,
   input  wire logic              a1_oe,
   input  wire logic [1:0]        mode0,
   input  wire logic [1:0]        mode1,
   input  wire logic signed [7:0] rem_v,
   input  wire logic signed [7:0] loc_v,
   input  wire logic [3:0]        gap,
   output logic                   meas_valid,
   output logic signed [7:0]      meas_data,
   output logic                   a0_i,
   output logic                   a1_i
);
   int   n     = 0;
   int   cnt   = 0;
   logic ph_q  = 1'b0;
   logic tog_q = 1'b0;
   // Tied pin beats the weak sense drive; open pin floats
   function automatic logic lvl(logic [1:0] m, logic o, logic oe, logic t);
      return (m == 2'h0) ? 1'b0 : (m == 2'h2) ? 1'b1 : (oe ? o : t);
   endfunction : lvl
   assign a0_i = lvl(mode0, a0_o, a0_oe, tog_q);
   assign a1_i = lvl(mode1, a1_o, a1_oe, ~tog_q);
   initial begin
      meas_valid = 1'b0;
      meas_data = 8'sh00;
   end
   always @(posedge clk_sys) begin
      tog_q <= ~tog_q;
      ph_q <= sense_remote_q;
      if (!meas_en_q || sense_remote_q != ph_q) begin
         n = 0;
         cnt = 0;
         meas_valid <= 1'b0;
         meas_data <= ~meas_data;
      end else if (cnt < gap) begin
         cnt++;
         meas_valid <= 1'b0;
         // Idle data keeps moving so no stale value passes
         meas_data <= ~meas_data;
      end else begin
         cnt = 0;
         meas_valid <= 1'b1;
         meas_data <= (sense_remote_q ? rem_v : loc_v) + 8'(n % 2);
         n++;
      end
   end
endmodule : dctm_far

// >>> tb/tb.sv
// Self-checking bench for the temperature monitor control block
`timescale 1ns/100ps
module tb;
   import dctm_pkg::*;
   logic              clk_sys, rst_n, hw_n, wr, os_req, clr, mv, men, srem;
   logic              a0i, a0o, a0oe, a1i, a1o, a1oe, alo, aloe;
   logic [2:0]        sel;
   logic [3:0]        st, gap;
   logic [6:0]        sa;
   logic [1:0]        m0, m1;
   logic [7:0]        wd, tl, tr, cfg, rate, ce;
   logic signed [7:0] md, rv, lv;
   int                err_total, comparisons, seed, cyc, starts, t_st;
   int                el, er, se, i, k, s, ta, d, pr;
   int                rts [3] = '{9, 6, 3};
   dctm_ctrl #(.CONV_CYCLES(40), .RATE_CYCLES(20)) dctm_ctrl_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1),
      .hw_sleep_n_input(hw_n), .addr_select0_pin_i(a0i),
      .addr_select0_pin_o(a0o), .addr_select0_pin_oe(a0oe),
      .addr_select1_pin_i(a1i), .addr_select1_pin_o(a1o),
      .addr_select1_pin_oe(a1oe), .reg_wr(wr), .reg_sel(sel),
      .reg_wdata(wd), .oneshot_req(os_req), .status_clr(clr),
      .meas_valid(mv), .meas_data(md), .meas_en_q(men),
      .sense_remote_q(srem), .temp_local_q(tl), .temp_remote_q(tr),
      .status_q(st), .cfg_q(cfg), .rate_q(rate), .slave_addr_q(sa),
      .alert_pin_o(alo), .alert_pin_oe(aloe));
   dctm_far dctm_far_inst (
      .clk_sys(clk_sys), .meas_en_q(men), .sense_remote_q(srem),
      .a0_o(a0o), .a0_oe(a0oe), .a1_o(a1o), .a1_oe(a1oe),
      .mode0(m0), .mode1(m1), .rem_v(rv), .loc_v(lv), .gap(gap),
      .meas_valid(mv), .meas_data(md), .a0_i(a0i), .a1_i(a1i));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;
   // Each rise of the pin drive marks a conversion start
   always @(posedge a0oe) begin
      starts = starts + 1;
      t_st = cyc;
   end
   task automatic cmp_v(string nm, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_v
   task automatic cmp_b(string nm, logic e, logic g);
      cmp_v(nm, {7'h00, e}, {7'h00, g});
   endtask : cmp_b
   task automatic wr_reg(logic [2:0] s_, logic [7:0] d_);
      sel <= s_;
      wd <= d_;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
      @(posedge clk_sys);
   endtask : wr_reg
   // Kind 0 one-shot, 1 status clear
   task automatic pulse(int w);
      os_req <= (w == 0);
      clr <= (w == 1);
      @(posedge clk_sys);
      os_req <= 1'b0;
      clr <= 1'b0;
      @(posedge clk_sys);
   endtask : pulse
   task automatic wait_starts(int n);
      for (i = 0; i < 5000 && starts < s + n; i++) @(posedge clk_sys);
   endtask : wait_starts
   task automatic conv(int g);
      int r;
      int l;
      r = $random(seed) % 100;
      l = $random(seed) % 100;
      gap <= 4'(g);
      rv <= 8'(r);
      lv <= 8'(l);
      // Samples alternate v and v+1, so truncation toward zero shows
      er = (10 * r + 5) / 10;
      el = (10 * l + 5) / 10;
      s = starts;
      pulse(0);
      wait_starts(1);
      for (i = 0; i < 300 && !srem; i++) @(posedge clk_sys);
      for (i = 0; i < 300 && srem; i++) @(posedge clk_sys);
      for (i = 0; i < 300 && !(tl === 8'(el) && tr === 8'(er)); i++)
         @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
      se = se | {er < -16, er > 16, el < -32, el > 32};
      cmp_v("temp_local", 8'(el), tl);
      cmp_v("temp_remote", 8'(er), tr);
      cmp_b("sign", er < 0, tr[7]);
      cmp_v("status", 8'(se), {4'h0, st});
      cmp_b("alert", (se != 0) && !ce[7], aloe);
   endtask : conv
   task automatic wrap_up;
      if (err_total == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (40000) @(posedge clk_sys);
      err_total = err_total + 1;
      wrap_up;
   end
   initial begin
      seed = 32'he80d2b68;
      {cyc, starts, err_total, comparisons, se, t_st} = '0;
      {wr, os_req, clr, sel, wd, m0, m1, rv, lv, ce} = '0;
      gap = 4'h2;
      hw_n = 1'b1;
      rst_n = 1'b0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      cmp_v("cfg", 8'h00, cfg);
      cmp_v("rate", 8'h02, rate);
      cmp_v("addr", 8'h18, {1'b0, sa});
      cmp_v("status", 8'h00, {4'h0, st});
      cmp_b("alert", 1'b0, aloe);
      cmp_b("alert_level", 1'b0, alo);
      wr_reg(3'h6, 8'hff);
      wr_reg(3'h7, 8'h41);
      cmp_v("cfg", 8'h00, cfg);
      cmp_v("rate", 8'h02, rate);
      ce = 8'h40;
      wr_reg(3'h0, ce);
      wr_reg(3'h2, 8'h20);
      wr_reg(3'h3, 8'he0);
      wr_reg(3'h4, 8'h10);
      wr_reg(3'h5, 8'hf0);
      cmp_v("cfg", ce, cfg);
      // Idle wait; sleep bit was set before the first auto start was due
      repeat (300) @(posedge clk_sys);
      for (k = 0; k < 9; k++) begin
         m0 <= 2'(k / 3);
         m1 <= 2'(k % 3);
         ce = {k[0], 7'h40};
         wr_reg(3'h0, ce);
         pulse(1);
         se = 0;
         cmp_v("status_clr", 8'h00, {4'h0, st});
         cmp_v("addr_hold", {1'b0, ADDR_TAB[k == 0 ? 0 : k - 1]},
               {1'b0, sa});
         conv(2 + 4 * (k % 2));
         cmp_v("addr", {1'b0, ADDR_TAB[k]}, {1'b0, sa});
      end
      rv <= 8'sh55;
      lv <= 8'sh2a;
      gap <= 4'h6;
      s = starts;
      pulse(0);
      for (i = 0; i < 300 && !srem; i++) @(posedge clk_sys);
      hw_n <= 1'b0;
      repeat (100) @(posedge clk_sys);
      cmp_v("temp_local", 8'(el), tl);
      cmp_v("temp_remote", 8'(er), tr);
      cmp_b("meas_en", 1'b0, men);
      s = starts;
      pulse(0);
      repeat (200) @(posedge clk_sys);
      cmp_v("starts", 8'(s), 8'(starts));
      cmp_v("cfg", ce, cfg);
      hw_n <= 1'b1;
      repeat (800) @(posedge clk_sys);
      cmp_v("starts", 8'(s), 8'(starts));
      ce = 8'h00;
      wr_reg(3'h0, ce);
      gap <= 4'h2;
      for (k = 0; k < 3; k++) begin
         wr_reg(3'h1, 8'(rts[k]));
         cmp_v("rate", 8'(rts[k]), rate);
         s = starts;
         wait_starts(2);
         ta = t_st;
         s = starts;
         wait_starts(1);
         pr = 20 << (7 - (rts[k] > 7 ? 7 : rts[k]));
         d = t_st - ta;
         // Start to start: the period, or a whole conversion if longer
         cmp_b("period", 1'b1,
               pr > 130 ? d == pr : (d >= 80 && d <= 130));
      end
      wrap_up;
   end
endmodule : tb
